// file: hw/gpio_pkg.sv
package gpio_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_DIR_WORD = 8'h00;
    localparam logic [7:0] ADDR_DRIVE_WORD = 8'h04;
    localparam logic [7:0] ADDR_SAMPLED_WORD = 8'h08;
    localparam logic [7:0] ADDR_DIR_LOW = 8'h0C;
    localparam logic [7:0] ADDR_DIR_HIGH = 8'h10;
    localparam logic [7:0] ADDR_DRIVE_LOW = 8'h14;
    localparam logic [7:0] ADDR_DRIVE_HIGH = 8'h18;
    localparam logic [7:0] ADDR_SAMPLED_LOW = 8'h1C;
    localparam logic [7:0] ADDR_SAMPLED_HIGH = 8'h20;
    localparam logic [7:0] ADDR_PIN_CMD = 8'h24;
    localparam logic [7:0] ADDR_POWER_CMD = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2C;
    localparam logic [7:0] ADDR_WDOG_KICK = 8'h30;
    // pin command fields: bits 3:0 pin index, bit 8 level, bit 9 go
    localparam int PIN_IDX_LSB = 0;
    localparam int PIN_LEVEL_BIT = 8;
    localparam int PIN_GO_BIT = 9;
    // power command codes, low 3 bits
    localparam logic [2:0] PCMD_SLEEP = 3'h1;
    localparam logic [2:0] PCMD_DOZE = 3'h2;
    localparam logic [2:0] PCMD_END = 3'h3;
    localparam logic [2:0] PCMD_HALT = 3'h4;
    localparam logic [2:0] PCMD_WAKE = 3'h5;
    // reset values
    localparam logic [15:0] DIR_RESET = 16'h0000;
    localparam logic [15:0] DRIVE_RESET = 16'h0000;
    // timing
    localparam longint CLK_HZ = 100000000;
    localparam longint WAKE_PERIOD_MS = 2300;
    localparam longint RELEASE_MS = 18;
    localparam longint WDOG_MS = 2300;
    localparam longint WAKE_CYCLES = WAKE_PERIOD_MS * CLK_HZ / 1000;
    localparam longint RELEASE_CYCLES = RELEASE_MS * CLK_HZ / 1000;
    localparam longint WDOG_CYCLES = WDOG_MS * CLK_HZ / 1000;
    // power states
    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_DOZE = 4'b0010,
        ST_HALT = 4'b0100,
        ST_DEAD = 4'b1000
    } power_state_t;
endpackage

// file: hw/pin_sync.sv
`timescale 1ns/10ps
// three-stage pin synchroniser, change taken when stages two and three agree
module pin_sync #(
    parameter int W = 16
) (
    input wire logic clk, // clock
    input wire logic rst_n, // async reset
    input wire logic [W-1:0] pin_in, // raw pins
    output logic [W-1:0] pin_sync_out // filtered pins
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;
    wire [W-1:0] agree = ~(s2_r ^ s3_r);
    wire [W-1:0] out_nxt = (agree & s3_r) | (~agree & out_r);
    // stage chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end
    assign pin_sync_out = out_r;
endmodule

// file: hw/cycle_timer.sv
`timescale 1ns/10ps
// down counter, done pulses when count expires, restart reloads
module cycle_timer #(
    parameter longint COUNT = 100
) (
    input wire logic clk, // clock
    input wire logic rst_n, // async reset
    input wire logic run, // count while high
    input wire logic restart, // reload count
    output logic done // one-cycle expiry pulse
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LOAD = CW'(COUNT - 1);
    logic [CW-1:0] cnt_r;
    logic done_r;
    wire zero = (cnt_r == '0);
    // reload on restart, while run is low, or on expiry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= LOAD;
            done_r <= 1'b0;
        end else if (restart || !run) begin
            cnt_r <= LOAD;
            done_r <= 1'b0;
        end else if (zero) begin
            cnt_r <= LOAD;
            done_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r - CW'(1);
            done_r <= 1'b0;
        end
    end
    assign done = done_r;
endmodule

// file: hw/gpio_direction_output_port.sv
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// RL1 - direction bit one makes pin output, zero makes it input
// RL2 - direction word sixteen bits, one per pin; eight-pin variant by parameter
// RL3 - drive level bit one drives high, zero low, only when output
// RL4 - reset leaves every pin an input
// RL5 - level writes to input pins are stored but do not reach the pin
// RL6 - set-high and set-low commands also make the pin an output
// RL7 - sampled word reads all pins; byte views give low and high halves
// RL8 - watchdog resets the controller when software stops kicking it
// RL9 - sleep and doze wake periodically every 2.3 seconds
// RL10 - each reset or wake releases pins to inputs for 18 ms, then restores
// RL11 - end enters low power with release; halt keeps outputs driven
// RL12 - after end the port ignores writes until reset
// RL13 - byte view writes change only their own eight bits
module gpio_direction_output_port
    import gpio_pkg::*;
#(
    parameter int PINS = 16,
    parameter longint WAKE_CNT = gpio_pkg::WAKE_CYCLES,
    parameter longint RELEASE_CNT = gpio_pkg::RELEASE_CYCLES,
    parameter longint WDOG_CNT = gpio_pkg::WDOG_CYCLES
) (
    input wire logic clk, // 100 MHz clock
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [PINS-1:0] pin_i, // pin levels in
    output logic [PINS-1:0] pin_o, // pin drive levels
    output logic [PINS-1:0] pin_oe, // pin output enables
    output logic wdog_reset // watchdog controller reset pulse
);
    // half width for the byte views, index width for pin commands
    localparam int HW = PINS / 2;
    localparam int IW = $clog2(PINS);

    // port words, pin drivers, timers and power state
    logic [PINS-1:0] dir_r;
    logic [PINS-1:0] dir_nxt;
    logic [PINS-1:0] drive_r;
    logic [PINS-1:0] drive_nxt;
    logic [PINS-1:0] pin_o_r;
    logic [PINS-1:0] pin_oe_r;
    logic [PINS-1:0] sampled;
    logic release_r;
    logic release_nxt;
    logic release_start;
    logic release_done;
    logic wake_done;
    logic wdog_done;
    logic wdog_r;
    power_state_t state_r;
    power_state_t state_nxt;

    // write channel capture, address and data in either order
    logic [7:0] awaddr_r;
    logic aw_have_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_have_r;
    logic bvalid_r;
    logic bresp_r;
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic rresp_r;

    // channel acceptance; a write commits once both halves are held
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    // ready while the holding slot is free and no response waits
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r ? 2'h2 : 2'h0;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r ? 2'h2 : 2'h0;

    // input pin synchroniser
    pin_sync #(.W(PINS)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(pin_i),
        .pin_sync_out(sampled)
    );

    // write address decode
    wire dead = (state_r == ST_DEAD);
    wire wr_on = wr_fire && !dead; // RL12
    wire wr_dir = wr_on && awaddr_r == ADDR_DIR_WORD;
    wire wr_drv = wr_on && awaddr_r == ADDR_DRIVE_WORD;
    wire wr_dir_lo = wr_on && awaddr_r == ADDR_DIR_LOW;
    wire wr_dir_hi = wr_on && awaddr_r == ADDR_DIR_HIGH;
    wire wr_drv_lo = wr_on && awaddr_r == ADDR_DRIVE_LOW;
    wire wr_drv_hi = wr_on && awaddr_r == ADDR_DRIVE_HIGH;
    wire wr_pin = wr_on && awaddr_r == ADDR_PIN_CMD
        && wdata_r[PIN_GO_BIT] && wstrb_r[1];
    wire wr_pwr = wr_on && awaddr_r == ADDR_POWER_CMD && wstrb_r[0];
    wire wr_kick = wr_fire && awaddr_r == ADDR_WDOG_KICK;
    // mapped offsets answer OKAY, also when the port ignores the write
    wire map_word = (awaddr_r == ADDR_DIR_WORD)
        || (awaddr_r == ADDR_DRIVE_WORD)
        || (awaddr_r == ADDR_SAMPLED_WORD);
    wire map_byte = (awaddr_r == ADDR_DIR_LOW) || (awaddr_r == ADDR_DIR_HIGH)
        || (awaddr_r == ADDR_DRIVE_LOW) || (awaddr_r == ADDR_DRIVE_HIGH)
        || (awaddr_r == ADDR_SAMPLED_LOW) || (awaddr_r == ADDR_SAMPLED_HIGH);
    wire map_ctrl = (awaddr_r == ADDR_PIN_CMD)
        || (awaddr_r == ADDR_POWER_CMD) || (awaddr_r == ADDR_STATUS)
        || (awaddr_r == ADDR_WDOG_KICK);
    wire wr_map = map_word || map_byte || map_ctrl; // RL12
    wire [IW-1:0] pin_idx = wdata_r[PIN_IDX_LSB +: IW];
    wire [2:0] pcmd = wdata_r[2:0];
    wire [PINS-1:0] lo_mask = {{(PINS-HW){1'b0}}, {HW{1'b1}}};
    wire [PINS-1:0] wd16 = wdata_r[PINS-1:0];
    wire [PINS-1:0] wd_hi = {wdata_r[HW-1:0], {HW{1'b0}}};
    wire [PINS-1:0] wd_lo = {{(PINS-HW){1'b0}}, wdata_r[HW-1:0]};
    wire [PINS-1:0] word_mask = {{HW{wstrb_r[1]}}, {HW{wstrb_r[0]}}};

    // direction and level next values
    always_comb begin
        dir_nxt = dir_r;
        drive_nxt = drive_r;
        if (wr_dir) begin
            dir_nxt = (dir_r & ~word_mask) | (wd16 & word_mask); // RL1 RL2
        end
        if (wr_dir_lo && wstrb_r[0]) begin
            dir_nxt = (dir_r & ~lo_mask) | wd_lo; // RL13
        end
        if (wr_dir_hi && wstrb_r[0]) begin
            dir_nxt = (dir_r & lo_mask) | wd_hi; // RL13
        end
        if (wr_drv) begin
            drive_nxt = (drive_r & ~word_mask) | (wd16 & word_mask); // RL5
        end
        if (wr_drv_lo && wstrb_r[0]) begin
            drive_nxt = (drive_r & ~lo_mask) | wd_lo; // RL13
        end
        if (wr_drv_hi && wstrb_r[0]) begin
            drive_nxt = (drive_r & lo_mask) | wd_hi; // RL13
        end
        if (wr_pin) begin
            dir_nxt[pin_idx] = 1'b1; // RL6
            drive_nxt[pin_idx] = wdata_r[PIN_LEVEL_BIT]; // RL6
        end
    end

    // direction and level store
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_r <= DIR_RESET[PINS-1:0]; // RL4
            drive_r <= DRIVE_RESET[PINS-1:0];
        end else begin
            dir_r <= dir_nxt;
            drive_r <= drive_nxt;
        end
    end

    // power state sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN: begin
                if (wr_pwr && (pcmd == PCMD_SLEEP || pcmd == PCMD_DOZE)) begin
                    state_nxt = ST_DOZE; // RL9
                end else if (wr_pwr && pcmd == PCMD_END) begin
                    state_nxt = ST_DEAD; // RL11
                end else if (wr_pwr && pcmd == PCMD_HALT) begin
                    state_nxt = ST_HALT; // RL11
                end
            end
            ST_DOZE: begin
                if (wr_pwr && pcmd == PCMD_WAKE) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_HALT: state_nxt = ST_HALT; // RL12
            ST_DEAD: state_nxt = ST_DEAD; // RL12
        endcase
    end

    // wake timer runs in doze and after end
    wire low_power = (state_r == ST_DOZE) || dead;
    cycle_timer #(.COUNT(WAKE_CNT)) u_wake (
        .clk(clk),
        .rst_n(rst_n),
        .run(low_power),
        .restart(1'b0),
        .done(wake_done) // RL9
    );

    // watchdog counts while running, kicked by software
    cycle_timer #(.COUNT(WDOG_CNT)) u_wdog (
        .clk(clk),
        .rst_n(rst_n),
        .run(state_r == ST_RUN),
        .restart(wr_kick),
        .done(wdog_done) // RL8
    );

    // release window after reset, wake or watchdog
    assign release_start = (wake_done && low_power) || wdog_done;
    cycle_timer #(.COUNT(RELEASE_CNT)) u_release (
        .clk(clk),
        .rst_n(rst_n),
        .run(release_r),
        .restart(release_start), // a new wake reopens the full window
        .done(release_done)
    );
    // start wins over expiry in the same cycle
    assign release_nxt = release_start ? 1'b1
        : (release_done ? 1'b0 : release_r); // RL10

    // power state, release window and watchdog pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RUN;
            release_r <= 1'b1; // RL10
            wdog_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            release_r <= release_nxt;
            wdog_r <= wdog_done; // RL8
        end
    end
    assign wdog_reset = wdog_r;

    // pin drivers, released pins float as inputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_oe_r <= '0; // RL4
            pin_o_r <= '0;
        end else begin
            pin_oe_r <= release_r ? '0 : dir_r; // RL1 RL10 RL11
            pin_o_r <= drive_r & dir_r; // RL3 RL5
        end
    end
    assign pin_oe = pin_oe_r;
    assign pin_o = pin_o_r;

    // read decode
    // status: one-hot state in bits 3:0, release flag in bit 7
    wire [31:0] status_word = {24'h0, release_r, 3'h0, state_r};
    logic [31:0] rd_val;
    logic rd_err;
    always_comb begin
        rd_err = 1'b0;
        unique case (s_axi_araddr)
            ADDR_DIR_WORD: rd_val = 32'(dir_r);
            ADDR_DRIVE_WORD: rd_val = 32'(drive_r);
            ADDR_SAMPLED_WORD: rd_val = 32'(sampled); // RL7
            ADDR_DIR_LOW: rd_val = 32'(dir_r[HW-1:0]);
            ADDR_DIR_HIGH: rd_val = 32'(dir_r[PINS-1:HW]);
            ADDR_DRIVE_LOW: rd_val = 32'(drive_r[HW-1:0]); // RL7
            ADDR_DRIVE_HIGH: rd_val = 32'(drive_r[PINS-1:HW]); // RL7
            ADDR_SAMPLED_LOW: rd_val = 32'(sampled[HW-1:0]); // RL7
            ADDR_SAMPLED_HIGH: rd_val = 32'(sampled[PINS-1:HW]); // RL7
            ADDR_STATUS: rd_val = status_word;
            ADDR_PIN_CMD: rd_val = 32'h0;
            ADDR_POWER_CMD: rd_val = 32'h0;
            ADDR_WDOG_KICK: rd_val = 32'h0;
            default: begin
                rd_val = 32'h0;
                rd_err = 1'b1;
            end
        endcase
    end

    // write address capture, low bits dropped for word alignment
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awaddr_r <= 8'h00;
            aw_have_r <= 1'b0;
        end else if (aw_take) begin
            awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
            aw_have_r <= 1'b1;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
        end
    end

    // write data capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            w_have_r <= 1'b0;
        end else if (w_take) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_have_r <= 1'b1;
        end else if (wr_fire) begin
            w_have_r <= 1'b0;
        end
    end

    // write response, held until the master takes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= 1'b0;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= !wr_map;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // read answer, data captured as the address is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h0;
            rvalid_r <= 1'b0;
            rresp_r <= 1'b0;
        end else if (ar_take) begin
            rdata_r <= rd_val;
            rresp_r <= rd_err;
            rvalid_r <= 1'b1;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule

// file: bench/gpio_port_properties.sv
`timescale 1ns/10ps
// bus timing and pin release checks at the port boundary
module gpio_port_checker #(
    parameter int PINS = 16
) (
    input wire logic clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic [1:0] s_axi_rresp, // r response
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [PINS-1:0] pin_oe, // pin enables
    input wire logic wdog_reset // watchdog pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // all pins let go for a stretch
    sequence s_released;
        (pin_oe == '0) [*4];
    endsequence
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_reset_release;
        $rose(rst_n) |-> s_released;
    endproperty
    property p_wdog_release;
        wdog_reset |-> ##[1:3] s_released;
    endproperty
    property p_wdog_pulse;
        wdog_reset |=> !wdog_reset;
    endproperty
    property p_b_time;
        s_both_taken |-> ##2 s_axi_bvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_time;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h30
            |=> s_axi_rresp == 2'b10;
    endproperty
    a_reset_release: assert property (p_reset_release)
        else $error("pins driven right after reset");
    a_wdog_release: assert property (p_wdog_release)
        else $error("pins not released after watchdog");
    a_wdog_pulse: assert property (p_wdog_pulse)
        else $error("watchdog pulse too long");
    a_b_time: assert property (p_b_time)
        else $error("write response late");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    a_r_time: assert property (p_r_time)
        else $error("read response late");
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
endmodule
bind gpio_direction_output_port gpio_port_checker #(.PINS(PINS)) chk_u (.*);

// file: bench/pin_partner.sv
`timescale 1ns/10ps
// external circuit, drives each pin only where the port lets go
module pin_partner #(
    parameter int PINS = 16
) (
    input wire logic [PINS-1:0] pin_o, // port drive
    input wire logic [PINS-1:0] pin_oe, // port enable
    input wire logic [PINS-1:0] ext_lvl, // external source
    output logic [PINS-1:0] pin_i // resolved wire
);
    // wire level from both parties
    assign pin_i = (pin_o & pin_oe) | (ext_lvl & ~pin_oe);
endmodule

// file: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import gpio_pkg::*;
    localparam int REL = 8;
    logic clk, rst_n, wdog_reset;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] pin_i, pin_o, pin_oe, ext_lvl;
    int n_errors, total_checks, dir_m, drv_m, v, k;
    gpio_direction_output_port #(.WAKE_CNT(50), .RELEASE_CNT(REL),
        .WDOG_CNT(200)) dut_u (.*);
    pin_partner part_u (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
        .pin_i(pin_i));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic lost(input string nm);
        n_errors++;
        $display("ERROR %s expected answer seen none", nm);
        close_out();
    endtask
    // one write, both halves offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (n == 2) s_axi_bready <= 1'b1; // response waits one cycle
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) lost("bresp");
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (n == 1) s_axi_rready <= 1'b1;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) lost("rdata");
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk("read data", e, rv);
    endtask
    // pins against the model once outputs settle
    task automatic pins_chk;
        repeat (3) @(posedge clk);
        chk("pin_oe", dir_m, pin_oe);
        chk("pin_o", dir_m & drv_m, pin_o);
    endtask
    task automatic wait_rel(input string nm, input int lim);
        int n;
        for (n = 0; n < lim && pin_oe !== '0; n++) @(posedge clk);
        if (n == lim) lost(nm);
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        dir_m = 0;
        drv_m = 0;
        repeat (REL + 4) @(posedge clk);
    endtask
    // main sequence
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, rst_n} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        ext_lvl = 16'h0000;
        n_errors = 0;
        total_checks = 0;
        v = $urandom(36);
        do_reset();
        chk("pin_oe", 0, pin_oe);
        rc(ADDR_DIR_WORD, DIR_RESET);
        rc(ADDR_DRIVE_WORD, DRIVE_RESET);
        $display("test reset done");
        for (k = 0; k < 4; k++) begin
            wr(ADDR_WDOG_KICK, 0);
            drv_m = $urandom & 32'hFFFF;
            wr(ADDR_DRIVE_WORD, drv_m);
            pins_chk();
            dir_m = $urandom & 32'hFFFF;
            wr(ADDR_DIR_WORD, dir_m);
            pins_chk();
            rc(ADDR_DIR_WORD, dir_m);
            rc(ADDR_DRIVE_WORD, drv_m);
        end
        $display("test words done");
        wr(ADDR_WDOG_KICK, 0);
        wr(ADDR_DIR_LOW, 32'hA5);
        dir_m = (dir_m & 32'hFF00) | 32'hA5;
        wr(ADDR_DRIVE_HIGH, 32'h3C);
        drv_m = (drv_m & 32'hFF) | 32'h3C00;
        pins_chk();
        rc(ADDR_DIR_WORD, dir_m);
        rc(ADDR_DIR_HIGH, dir_m >> 8);
        rc(ADDR_DRIVE_LOW, drv_m & 32'hFF);
        rc(ADDR_DRIVE_HIGH, drv_m >> 8);
        $display("test bytes done");
        wr(ADDR_WDOG_KICK, 0);
        for (k = 0; k < 4; k++) begin
            v = $urandom % 16;
            wr(ADDR_PIN_CMD, (1 << PIN_GO_BIT) | ((k % 2) << PIN_LEVEL_BIT) | v);
            dir_m = dir_m | (1 << v);
            drv_m = (drv_m & ~(1 << v)) | ((k % 2) << v);
            pins_chk();
        end
        $display("test pin commands done");
        ext_lvl <= 16'($urandom);
        repeat (8) @(posedge clk);
        v = (drv_m & dir_m) | (ext_lvl & ~dir_m & 32'hFFFF);
        rc(ADDR_SAMPLED_WORD, v);
        rc(ADDR_SAMPLED_LOW, v & 32'hFF);
        rc(ADDR_SAMPLED_HIGH, v >> 8);
        rd(8'h3C);
        chk("rresp", 2'b10, resp);
        wr(8'h3C, 1);
        chk("bresp", 2'b10, resp);
        $display("test sampling done");
        for (k = 0; k < 300 && wdog_reset !== 1'b1; k++) @(posedge clk);
        if (k == 300) lost("wdog_reset");
        repeat (3) @(posedge clk);
        chk("pin_oe", 0, pin_oe);
        repeat (REL + 3) @(posedge clk);
        pins_chk();
        $display("test watchdog done");
        for (k = 0; k < 2; k++) begin
            wr(ADDR_WDOG_KICK, 0);
            wr(ADDR_POWER_CMD, k == 0 ? PCMD_SLEEP : PCMD_DOZE);
            wait_rel("wake", 80);
            repeat (REL + 4) @(posedge clk);
            chk("pin_oe", dir_m, pin_oe);
            wr(ADDR_POWER_CMD, PCMD_WAKE);
        end
        $display("test doze done");
        wr(ADDR_POWER_CMD, PCMD_HALT);
        v = 0;
        for (k = 0; k < 120; k++) begin
            @(posedge clk);
            if (pin_oe !== dir_m[15:0]) v++;
        end
        chk("halt drops", 0, v);
        do_reset();
        $display("test halt done");
        wr(ADDR_DIR_WORD, 32'h00F0);
        dir_m = 32'hF0;
        wr(ADDR_POWER_CMD, PCMD_END);
        wr(ADDR_DIR_WORD, 32'h000F);
        chk("bresp", 0, resp);
        rc(ADDR_DIR_WORD, dir_m);
        rc(ADDR_STATUS, 32'(ST_DEAD));
        wait_rel("end wake", 80);
        do_reset();
        chk("pin_oe", 0, pin_oe);
        $display("test end done");
        close_out();
    end
endmodule
